// *** rtl/lbst_top.sv ***
// Loopback signature test logic of one channel, with AXI4-Lite control and a scan port.
// Assumes link lanes arrive pre-sampled with one-cycle strobes, and the scan port is
// synchronous to clock. Other channels have their own instance and are unaffected.
`timescale 1ns/1ns
`default_nettype none
`include "lbst_defines.svh"
module lbst_top #(
	parameter int NBYTES    = 16,
	parameter int LANES     = 10,
	parameter int CMD_LANES = 14,
	parameter int ADDR_W    = 8
) (
	input  wire logic                    clock,
	input  wire logic                    nrst,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADDR_W-1:0]       s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// Scan wrapper port
	input  wire logic                    wrst_n,
	input  wire logic [1:0]              scan_instr,
	input  wire logic                    scan_capture,
	input  wire logic                    scan_shift,
	input  wire logic                    scan_update,
	input  wire logic                    scan_si,
	output logic                         scan_so,
	// Data word group lanes: per byte, lanes 0-7 data, 8 inversion, 9 write mask
	input  wire logic [NBYTES*LANES-1:0] data_rise,
	input  wire logic [NBYTES*LANES-1:0] data_fall,
	input  wire logic                    data_wr_valid,
	input  wire logic                    data_rd_req,
	output logic [NBYTES*LANES-1:0]      data_out_rise,
	output logic [NBYTES*LANES-1:0]      data_out_fall,
	// Command word group lanes
	input  wire logic [CMD_LANES-1:0]    cmd_rise,
	input  wire logic [CMD_LANES-1:0]    cmd_fall,
	input  wire logic                    cke_in,
	input  wire logic                    clock_true_rise,
	input  wire logic                    powerdown,
	output logic                         cmd_decode_en,
	output logic                         cmd_buf_en,
	output logic                         data_buf_en
);
	localparam int DW     = `LBST_DATA_W;
	localparam int CW     = `LBST_CMD_W;
	localparam int SCAN_W = NBYTES * DW;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
		if (a[ADDR_W-1:2] == (ADDR_W-2)'(`LBST_OFS_LOOPBACK_MR >> 2))
			reg_sel = 2'h1;
		else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`LBST_OFS_STATUS >> 2))
			reg_sel = 2'h2;
		else
			reg_sel = 2'h0;
	endfunction

	logic                  have_aw_q;
	logic                  have_w_q;
	logic [ADDR_W-1:0]     awaddr_q;
	logic [31:0]           wdata_q;
	logic                  wbyte0_q;
	logic [2:0]            mr_q;
	logic [`LBST_CFG_W-1:0] cfg_q;
	logic [SCAN_W-1:0]     sr_q;
	logic [SCAN_W-1:0]     sr_d;
	logic                  keep_q;
	logic                  pd_q;
	lbst_pkg::lbst_state_t state_q;
	lbst_pkg::lbst_state_t state_d;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	wire logic       aw_hs    = s_axi_awvalid & s_axi_awready;
	wire logic       w_hs     = s_axi_wvalid & s_axi_wready;
	wire logic       do_write = have_aw_q & have_w_q & ~s_axi_bvalid;
	wire logic       have_aw_d = (have_aw_q | aw_hs) & ~do_write;
	wire logic       have_w_d  = (have_w_q | w_hs) & ~do_write;
	wire logic       bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
	wire logic [1:0] wsel      = reg_sel(awaddr_q);
	wire logic       mr_wr     = do_write & (wsel == 2'h1) & wbyte0_q;
	wire logic       ar_hs     = s_axi_arvalid & s_axi_arready;
	wire logic       rvalid_d  = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	wire logic [1:0] rsel      = reg_sel(s_axi_araddr);
	wire logic [31:0] status_word;
	wire logic [31:0] rdata_d = (rsel == 2'h1) ? {29'h0, mr_q} :
	                            (rsel == 2'h2) ? status_word : 32'h0;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			have_aw_q     <= 1'b0;
			have_w_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= 32'h0;
			wbyte0_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `LBST_RESP_OKAY;
		end else begin
			have_aw_q     <= have_aw_d;
			have_w_q      <= have_w_d;
			s_axi_awready <= ~have_aw_d & ~bvalid_d;
			s_axi_wready  <= ~have_w_d & ~bvalid_d;
			s_axi_bvalid  <= bvalid_d;
			if (aw_hs)
				awaddr_q <= s_axi_awaddr;
			if (w_hs) begin
				wdata_q  <= s_axi_wdata;
				wbyte0_q <= s_axi_wstrb[0];
			end
			// Status is read-only, so only the mode register accepts writes
			if (do_write)
				s_axi_bresp <= (wsel == 2'h1) ? `LBST_RESP_OKAY : `LBST_RESP_SLVERR;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `LBST_RESP_OKAY;
		end else begin
			s_axi_arready <= ~rvalid_d;
			s_axi_rvalid  <= rvalid_d;
			if (ar_hs) begin
				s_axi_rdata <= rdata_d;
				s_axi_rresp <= (rsel == 2'h0) ? `LBST_RESP_SLVERR : `LBST_RESP_OKAY;
			end
		end
	end

	// ------------------------------------------------------------
	// Mode enables
	// ------------------------------------------------------------
	// Loopback mode register lives until device reset, never cleared by wrapper reset
	always_ff @(posedge clock) begin
		if (!nrst)
			mr_q <= 3'h0; // [RQ21]
		else if (mr_wr)
			mr_q <= wdata_q[2:0]; // [RQ10]
	end

	wire logic cfg_upd = scan_update & (scan_instr == `LBST_INSTR_CMD_CFG);

	always_ff @(posedge clock) begin
		if (!nrst || !wrst_n)
			cfg_q <= '0; // [RQ15]
		else if (cfg_upd)
			cfg_q <= sr_q[`LBST_CFG_W-1:0]; // [RQ10]
	end

	wire logic                 dw_req  = mr_q[`LBST_MR_EN_BIT];
	wire logic                 cw_req  = cfg_q[`LBST_CFG_EN_BIT];
	wire lbst_pkg::lbst_mode_t dw_mode = lbst_pkg::lbst_mode_t'(mr_q[`LBST_MR_MODE_LSB +: 2]);
	wire lbst_pkg::lbst_mode_t cw_mode = lbst_pkg::lbst_mode_t'(cfg_q[`LBST_CFG_MODE_LSB +: 2]);

	// First group enabled wins, data if both come in one cycle; the other stays parked until it drops
	always_comb begin
		state_d = state_q;
		case (state_q)
			lbst_pkg::LBST_ST_NORMAL: begin
				if (dw_req)
					state_d = lbst_pkg::LBST_ST_DATA;
				else if (cw_req)
					state_d = lbst_pkg::LBST_ST_CMD;
			end
			lbst_pkg::LBST_ST_DATA: begin
				if (!dw_req)
					state_d = lbst_pkg::LBST_ST_NORMAL;
			end
			lbst_pkg::LBST_ST_CMD: begin
				if (!cw_req)
					state_d = lbst_pkg::LBST_ST_NORMAL;
			end
			default: state_d = lbst_pkg::LBST_ST_NORMAL;
		endcase
	end

	wire logic dw_act = (state_q == lbst_pkg::LBST_ST_DATA);
	wire logic cw_act = (state_q == lbst_pkg::LBST_ST_CMD);
	// Loopback already on when power-down starts keeps every buffer alive
	wire logic keep_d = powerdown & (pd_q ? keep_q : dw_req);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q       <= lbst_pkg::LBST_ST_NORMAL;
			pd_q          <= 1'b0;
			keep_q        <= 1'b0;
			cmd_decode_en <= 1'b1;
			cmd_buf_en    <= 1'b1;
			data_buf_en   <= 1'b1;
		end else begin
			state_q       <= state_d; // [RQ11]
			pd_q          <= powerdown;
			keep_q        <= keep_d; // [RQ17]
			cmd_decode_en <= ~(state_d == lbst_pkg::LBST_ST_CMD); // [RQ24]
			cmd_buf_en    <= ~powerdown | keep_d | (state_d == lbst_pkg::LBST_ST_CMD); // [RQ13] [RQ17]
			data_buf_en   <= ~powerdown | keep_d; // [RQ17]
		end
	end

	assign status_word = {26'h0, keep_q, data_buf_en, cmd_buf_en, cmd_decode_en, cw_act, dw_act};

	// ------------------------------------------------------------
	// Signature registers
	// ------------------------------------------------------------
	wire logic [SCAN_W-1:0] data_sig;
	wire logic [CW-1:0]     cmd_sig;
	wire logic [CW-1:0]     cmd_din;
	// Pattern generation follows reads, capture and compression follow writes
	wire logic              dw_step = (dw_mode == lbst_pkg::LBST_MODE_LFSR) ? data_rd_req : data_wr_valid;

	genvar b;
	genvar l;
	generate
		for (b = 0; b < NBYTES; b++) begin : g_byte
			wire logic [DW-1:0] din;
			for (l = 0; l < LANES; l++) begin : g_lane
				assign din[2*l]     = data_rise[b*LANES+l]; // [RQ1]
				assign din[2*l+1]   = data_fall[b*LANES+l];
				assign data_out_rise[b*LANES+l] = data_sig[b*DW+2*l];
				assign data_out_fall[b*LANES+l] = data_sig[b*DW+2*l+1];
			end
			lbst_sig_reg #(
				.W      (DW),
				.TAPS   (`LBST_DATA_TAPS),
				.PRESET (`LBST_DATA_PRESET)
			) u_byte (
				.clock  (clock),
				.nrst   (nrst),
				.active (dw_act),
				.step   (dw_step),
				.mode   (dw_mode),
				.din    (din),
				.q      (data_sig[b*DW +: DW])
			); // [RQ2] [RQ8]
		end
		for (l = 0; l < CMD_LANES; l++) begin : g_cmd
			assign cmd_din[2*l]   = cmd_rise[l]; // [RQ3]
			assign cmd_din[2*l+1] = cmd_fall[l];
		end
	endgenerate

	// Clock-enable is single rate: the rising sample fills both bits
	assign cmd_din[CW-2] = cke_in; // [RQ25]
	assign cmd_din[CW-1] = cke_in; // [RQ25]

	lbst_sig_reg #(
		.W      (CW),
		.TAPS   (`LBST_CMD_TAPS),
		.PRESET (`LBST_CMD_PRESET)
	) u_cmd (
		.clock  (clock),
		.nrst   (nrst),
		.active (cw_act),
		.step   (clock_true_rise),
		.mode   (cw_mode),
		.din    (cmd_din),
		.q      (cmd_sig)
	); // [RQ3] [RQ7] [RQ25]

	// ------------------------------------------------------------
	// Scan data register
	// ------------------------------------------------------------
	// Length follows the instruction so short registers need no padding bits
	wire logic [8:0] scan_top = (scan_instr == `LBST_INSTR_DATA_SIG) ? 9'(SCAN_W - 1) :
	                            (scan_instr == `LBST_INSTR_CMD_SIG)  ? 9'(CW - 1) :
	                                                                    9'(`LBST_CFG_W - 1);

	always_comb begin
		sr_d = sr_q;
		if (scan_capture) begin
			case (scan_instr)
				`LBST_INSTR_DATA_SIG: sr_d = data_sig; // [RQ4]
				`LBST_INSTR_CMD_SIG:  sr_d = {{(SCAN_W-CW){1'b0}}, cmd_sig}; // [RQ5]
				`LBST_INSTR_CMD_CFG:  sr_d = {{(SCAN_W-`LBST_CFG_W){1'b0}}, cfg_q};
				default:              sr_d = sr_q;
			endcase
		end else if (scan_shift) begin
			sr_d = sr_q >> 1; // [RQ4]
			sr_d[scan_top] = scan_si;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			sr_q    <= '0;
			scan_so <= 1'b0;
		end else begin
			sr_q    <= sr_d;
			scan_so <= sr_d[0];
		end
	end
endmodule
`default_nettype wire

// *** include/lbst_defines.svh ***
// Constants of the loopback signature test logic: offsets, fields, presets, taps, codes.
// Assumes one 100 MHz clock; included by its bare name wherever a number is needed.
//
// Overview of operation
// RQ1 - Each data byte owns a 20-bit register: rise and fall bits, ten lanes.
// RQ2 - Byte registers step and load independently of each other.
// RQ3 - One 30-bit command register: rise and fall bits of command lanes and clock-enable.
// RQ4 - Data signature scan shifts out all sixteen bytes of the channel, 320 bits.
// RQ5 - Command signature scan instruction reads the 30-bit command register.
// RQ6 - Registers preset to fixed alternating ones-and-zeros pattern instead of clearing to zero.
// RQ7 - Command register feedback taps at powers 30, 6, 4, 1, 0.
// RQ8 - Data byte register feedback taps at powers 20, 17, 0.
// RQ9 - Host never runs command and data signature modes together.
// RQ10 - Data modes via loopback mode register, command modes via scan config, after init.
// RQ11 - Signature modes on this channel leave other channels untouched.
// RQ12 - Host idles banks, powers down, stops clock before command modes.
// RQ13 - Command modes re-enable command input buffers during power-down.
// RQ14 - Early enable after third init interval skips power-down entry and exit.
// RQ15 - Wrapper reset clears the command signature enable bit.
// RQ16 - Host data-mode sequence: idle, set registers, enable, wait, power down.
// RQ17 - Data loopback enabled before power-down keeps all I/O buffers enabled.
// RQ18 - During data modes host sends only reads, writes, no-ops, loopback register writes.
// RQ19 - Before fifth init interval host loads mode registers by scan.
// RQ20 - Early data loopback sequence: clock with no-ops, scan enable, operate, disable.
// RQ21 - Device reset clears the data loopback enable bit.
// RQ22 - Host may skip exit and leave loopback enabled if mission mode not needed.
// RQ23 - Preset loads AAAAAh per data byte and 2AAAAAAh into command register.
// RQ24 - Command decoding is disabled while command signature modes are enabled.
// RQ25 - Clock-enable sampled on rising true edge only, loaded into both its bits.
// RQ26 - Compression combines captured lanes with shifted feedback state, Galois form.
`ifndef LBST_DEFINES_SVH
`define LBST_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LBST_OFS_LOOPBACK_MR   8'h00
`define LBST_OFS_STATUS        8'h04
`define LBST_MR_EN_BIT         0
`define LBST_MR_MODE_LSB       1
`define LBST_ST_DATA_BIT       0
`define LBST_ST_CMD_BIT        1
`define LBST_ST_DECODE_BIT     2
`define LBST_ST_CMD_BUF_BIT    3
`define LBST_ST_DATA_BUF_BIT   4
`define LBST_ST_KEEP_BIT       5
`define LBST_RESP_OKAY         2'h0
`define LBST_RESP_SLVERR       2'h2

// ----------------------------------------------------------------
// Signature registers
// ----------------------------------------------------------------
`define LBST_DATA_W            20
`define LBST_CMD_W             30
`define LBST_DATA_PRESET       20'hAAAAA
`define LBST_CMD_PRESET        30'h2AAAAAA
`define LBST_DATA_TAPS         20'h20001
`define LBST_CMD_TAPS          30'h0000053

// ----------------------------------------------------------------
// Scan instructions and config layout
// ----------------------------------------------------------------
`define LBST_INSTR_DATA_SIG    2'h1
`define LBST_INSTR_CMD_SIG     2'h2
`define LBST_INSTR_CMD_CFG     2'h3
`define LBST_CFG_W             3
`define LBST_CFG_EN_BIT        0
`define LBST_CFG_MODE_LSB      1

`endif

// *** include/lbst_pkg.sv ***
// Types of the loopback signature test logic.
// Assumes nothing of its surroundings; used as lbst_pkg::name.
package lbst_pkg;

	// Signature register function, two mode bits
	typedef enum logic [1:0] {
		LBST_MODE_PRESET = 2'h0,
		LBST_MODE_LFSR   = 2'h1,
		LBST_MODE_REG    = 2'h2,
		LBST_MODE_MISR   = 2'h3
	} lbst_mode_t;

	// Which group the channel is testing
	typedef enum logic [2:0] {
		LBST_ST_NORMAL = 3'h1,
		LBST_ST_DATA   = 3'h2,
		LBST_ST_CMD    = 3'h4
	} lbst_state_t;

endpackage

// *** rtl/lbst_sig_reg.sv ***
// One signature/pattern register: preset, pattern generator, capture or compression.
// Assumes step is a one-cycle pulse per captured edge pair, din already interleaved rise/fall.
`timescale 1ns/1ns
`default_nettype none
module lbst_sig_reg #(
	parameter int              W      = 20,
	parameter logic [W-1:0]    TAPS   = '0,
	parameter logic [W-1:0]    PRESET = '0
) (
	input  wire logic                clock,
	input  wire logic                nrst,
	input  wire logic                active,
	input  wire logic                step,
	input  wire lbst_pkg::lbst_mode_t mode,
	input  wire logic [W-1:0]        din,
	output logic      [W-1:0]        q
);
	// Galois shift: top bit feeds every tap position
	function automatic logic [W-1:0] galois(input logic [W-1:0] s);
		galois = {s[W-2:0], 1'b0} ^ (s[W-1] ? TAPS : '0);
	endfunction

	wire logic [W-1:0] fb_next = galois(q);
	wire logic [W-1:0] comp_next = fb_next ^ din;
	wire logic         hold_preset = active && (mode == lbst_pkg::LBST_MODE_PRESET);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			q <= PRESET; // [RQ6]
		end else if (hold_preset) begin
			q <= PRESET; // [RQ6] [RQ23]
		end else if (active && step) begin
			case (mode)
				lbst_pkg::LBST_MODE_LFSR: q <= fb_next; // [RQ7] [RQ8]
				lbst_pkg::LBST_MODE_REG:  q <= din;
				lbst_pkg::LBST_MODE_MISR: q <= comp_next; // [RQ26]
				default:                  q <= q;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** test/lbst_top_chk.sv ***
// Port checks of lbst_top: bus answers, buffer enables, decode and config reset.
// Assumes it is bound into lbst_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module lbst_top_chk (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       wrst_n,
	input wire logic       powerdown,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       cmd_decode_en,
	input wire logic       cmd_buf_en,
	input wire logic       data_buf_en
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	chk_b_latency: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after take");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after handshake");
	chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address ready high after take");
	chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after take");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	// ----------------------------------------------------------------
	// Link side
	// ----------------------------------------------------------------
	chk_data_buf: assert property (!powerdown |=> data_buf_en)
		else $error("data buffers off outside power-down");
	chk_cmd_buf: assert property ($fell(cmd_decode_en) |-> cmd_buf_en)
		else $error("command buffers off in command signature mode");
	chk_cfg_clear: assert property (!wrst_n |-> ##[1:3] cmd_decode_en)
		else $error("wrapper reset left decode disabled");
endmodule
bind lbst_top lbst_top_chk u_chk (.*);
`default_nettype wire

// *** test/lbst_host_model.sv ***
// Host side of the link: lanes and one-cycle capture strobes on request.
// Assumes requests from the bench; lanes change every cycle, never hold.
`timescale 1ns/1ns
`default_nettype none
module lbst_host_model (
	input  wire logic   clock,
	input  wire logic   wr_req,
	input  wire logic   rd_req,
	input  wire logic   cmd_req,
	output logic [159:0] data_rise = 160'h0,
	output logic [159:0] data_fall = 160'h0,
	output logic        data_wr_valid = 1'h0,
	output logic        data_rd_req = 1'h0,
	output logic [13:0] cmd_rise = 14'h0,
	output logic [13:0] cmd_fall = 14'h0,
	output logic        cke_in = 1'h0,
	output logic        clock_true_rise = 1'h0
);
	logic [31:0] rnd_q = 32'h1;
	// Fresh lanes each cycle so a sample taken on the wrong edge shows
	always_ff @(posedge clock) begin
		rnd_q <= rnd_q * 32'h0019660D + 32'h3C6EF35F;
		for (int b = 0; b < 16; b++) begin
			data_rise[b*10 +: 10] <= rnd_q[9:0] ^ 10'(b * 37);
			data_fall[b*10 +: 10] <= rnd_q[19:10] ^ 10'(b * 91);
		end
		cmd_rise <= rnd_q[13:0];
		cmd_fall <= rnd_q[27:14];
		cke_in <= rnd_q[31];
		data_wr_valid <= wr_req & ~cmd_req;
		data_rd_req <= rd_req & ~cmd_req;
		clock_true_rise <= cmd_req;
	end
endmodule
`default_nettype wire

// *** test/lbst_top_test.sv ***
// Bench of lbst_top: register map, data and command signatures, scan reads, buffers.
// Assumes lbst_host_model at the link and the checker bound by its own file.
`timescale 1ns/1ns
`default_nettype none
`include "lbst_defines.svh"
module lbst_top_test;
	typedef struct packed {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [3:0]  s;
		logic [1:0]  r;
		logic [31:0] q;
	} lbst_row_t;
	logic        clock = 1'h0;
	logic        nrst = 1'h0;
	logic        wrst_n = 1'h1;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, powerdown = 1'h0;
	logic        scan_capture = 1'h0, scan_shift = 1'h0, scan_update = 1'h0, scan_si = 1'h0;
	logic        wr_req = 1'h0, rd_req = 1'h0, cmd_req = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scan_so;
	logic [1:0]  scan_instr = 2'h0, s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic [159:0] data_rise, data_fall, data_out_rise, data_out_fall;
	logic [13:0] cmd_rise, cmd_fall;
	logic        data_wr_valid, data_rd_req, cke_in, clock_true_rise;
	logic        cmd_decode_en, cmd_buf_en, data_buf_en;
	logic [19:0] eq [16];
	logic [29:0] ec;
	logic [319:0] sv;
	int          n_errors = 0, n_compared = 0;
	lbst_row_t   rows [8] = '{
		'{1'h0, 8'h00, 32'h0, 4'h0, 2'h0, 32'h0},
		'{1'h1, 8'h00, 32'h7, 4'h1, 2'h0, 32'h0},
		'{1'h0, 8'h00, 32'h0, 4'h0, 2'h0, 32'h7},
		'{1'h0, 8'h04, 32'h0, 4'h0, 2'h0, 32'h1D},
		'{1'h1, 8'h04, 32'h0, 4'hF, 2'h2, 32'h0},
		'{1'h1, 8'h00, 32'h0, 4'h0, 2'h0, 32'h0},
		'{1'h0, 8'h00, 32'h0, 4'h0, 2'h0, 32'h7},
		'{1'h0, 8'h40, 32'h0, 4'h0, 2'h2, 32'h0}};
	lbst_top dut (.*);
	lbst_host_model u_host (.*);
	always #5 clock = ~clock;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [319:0] pack(input logic [159:0] r, input logic [159:0] f);
		for (int k = 0; k < 320; k++) pack[k] = k[0] ? f[k/2] : r[k/2];
	endfunction
	function automatic logic [319:0] ev();
		for (int b = 0; b < 16; b++) ev[b*20 +: 20] = eq[b];
	endfunction
	function automatic logic [19:0] gd(input logic [19:0] q);
		return {q[18:0], 1'h0} ^ (q[19] ? 20'h20001 : 20'h0);
	endfunction
	function automatic logic [29:0] gc(input logic [29:0] q);
		return {q[28:0], 1'h0} ^ (q[29] ? 30'h53 : 30'h0);
	endfunction
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [319:0] e, input logic [319:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang();
		n_errors++;
		$display("[ERR] bus answer expected within 50 cycles seen none");
		print_verdict();
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Master holds each valid until its own ready edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int t;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (t = 0; t < 50; t++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
		end
		if (t == 50) hang();
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (t = 0; t < 50; t++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
		end
		if (t == 50) hang();
	endtask
	task automatic scan_rd(input logic [1:0] ins, input int n);
		@(posedge clock);
		scan_instr <= ins;
		scan_capture <= 1'h1;
		@(posedge clock);
		scan_capture <= 1'h0;
		scan_shift <= 1'h1;
		for (int k = 0; k < n; k++) begin
			if (k > 0) @(posedge clock);
			#1 sv[k] = scan_so;
		end
		@(posedge clock);
		scan_shift <= 1'h0;
	endtask
	task automatic scan_cfg(input logic [2:0] c);
		@(posedge clock);
		scan_instr <= `LBST_INSTR_CMD_CFG;
		scan_shift <= 1'h1;
		for (int k = 0; k < 3; k++) begin
			scan_si <= c[k];
			@(posedge clock);
		end
		scan_shift <= 1'h0;
		scan_update <= 1'h1;
		@(posedge clock);
		scan_update <= 1'h0;
	endtask
	// Mode 3 compresses, 2 captures, 1 steps the pattern on a read strobe
	task automatic dstep(input logic [1:0] m);
		logic [319:0] d;
		@(posedge clock);
		if (m == 2'h1) rd_req <= 1'h1;
		else wr_req <= 1'h1;
		@(posedge clock);
		wr_req <= 1'h0;
		rd_req <= 1'h0;
		#1 d = pack(data_rise, data_fall);
		for (int b = 0; b < 16; b++) eq[b] = m == 2'h2 ? d[b*20 +: 20] : gd(eq[b]) ^ (m == 2'h3 ? d[b*20 +: 20] : 20'h0);
		wait_n(1);
		check("data signature", ev(), pack(data_out_rise, data_out_fall));
	endtask
	task automatic cstep(input logic cap);
		logic [319:0] p;
		logic [29:0]  d;
		@(posedge clock);
		cmd_req <= 1'h1;
		@(posedge clock);
		cmd_req <= 1'h0;
		#1 p = pack(160'(cmd_rise), 160'(cmd_fall));
		d = {cke_in, cke_in, p[27:0]};
		ec = cap ? d : gc(ec) ^ d;
		@(posedge clock);
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		for (int b = 0; b < 16; b++) eq[b] = `LBST_DATA_PRESET;
		ec = `LBST_CMD_PRESET;
		repeat (2) @(posedge clock);
		nrst <= 1'h1;
		#1 check("preset", ev(), pack(data_out_rise, data_out_fall));
		check("decode", 1'h1, cmd_decode_en);
		for (int i = 0; i < 8; i++) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].a, rows[i].d, rows[i].s, rr);
			end else begin
				axi_rd(rows[i].a, rv, rr);
				check("read data", rows[i].q, rv);
			end
			check("response", rows[i].r, rr);
		end
		$display("test register map done");
		@(posedge clock);
		powerdown <= 1'h1;
		wait_n(3);
		check("data buffers", 1'h1, data_buf_en);
		check("command buffers", 1'h1, cmd_buf_en);
		dstep(2'h3);
		dstep(2'h3);
		axi_wr(8'h00, 32'h5, 4'h1, rr);
		dstep(2'h2);
		axi_wr(8'h00, 32'h3, 4'h1, rr);
		dstep(2'h1);
		dstep(2'h1);
		scan_rd(`LBST_INSTR_DATA_SIG, 320);
		check("data scan", ev(), sv);
		@(posedge clock);
		powerdown <= 1'h0;
		axi_wr(8'h00, 32'h0, 4'h1, rr);
		@(posedge clock);
		powerdown <= 1'h1;
		wait_n(3);
		check("data buffers off", 1'h0, data_buf_en);
		check("command buffers off", 1'h0, cmd_buf_en);
		$display("test data signature done");
		scan_cfg(3'h7);
		wait_n(3);
		check("decode off", 1'h0, cmd_decode_en);
		check("command buffers on", 1'h1, cmd_buf_en);
		cstep(1'h0);
		cstep(1'h0);
		scan_rd(`LBST_INSTR_CMD_SIG, 30);
		check("command scan", ec, sv[29:0]);
		scan_cfg(3'h5);
		cstep(1'h1);
		scan_rd(`LBST_INSTR_CMD_SIG, 30);
		check("command capture", ec, sv[29:0]);
		@(posedge clock);
		wrst_n <= 1'h0;
		@(posedge clock);
		wrst_n <= 1'h1;
		wait_n(3);
		check("decode back", 1'h1, cmd_decode_en);
		check("command buffers idle", 1'h0, cmd_buf_en);
		$display("test command signature done");
		@(posedge clock);
		powerdown <= 1'h0;
		axi_wr(8'h00, 32'h1, 4'h1, rr);
		wait_n(2);
		for (int b = 0; b < 16; b++) eq[b] = `LBST_DATA_PRESET;
		check("preset mode", ev(), pack(data_out_rise, data_out_fall));
		@(posedge clock);
		nrst <= 1'h0;
		repeat (2) @(posedge clock);
		nrst <= 1'h1;
		ec = `LBST_CMD_PRESET;
		scan_rd(`LBST_INSTR_CMD_SIG, 30);
		check("preset again", ec, sv[29:0]);
		axi_rd(8'h00, rv, rr);
		check("enable cleared", 32'h0, rv);
		$display("test device reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
